// File: hw/spsc_ctrl.sv
// System power state controller with APB registers
`timescale 1ns/1ps
`include "spsc_defines.svh"
//
// Operation
// [RL1] Active keeps all used memory and I/O powered and available.
// [RL2] Sleep level zero entered only when every core sleeps or deeper.
// [RL3] Sleep zero: retain enabled memory, NVM standby, HF RC on, core clocks gated.
// [RL4] Sleep level one also requires every peripheral idle.
// [RL5] Sleep one gates all functional clocks, power as in sleep zero.
// [RL6] Deep zero: selected TCM and cache retained, NVM off, CPU domain off.
// [RL7] Deep one equals deep zero but cache powered fully off.
// [RL8] Deep two: minimal memory, HF RC off, crystal on, switched domains off.
// [RL9] Software asks deep two only with peripherals idle or state saved.
// [RL10] Deep three: no memory, only LF RC and one timer run.
// [RL11] Off state is external supply removal; only NVM survives.
// [RL12] Wake restarts oscillators, restores power, ungates clocks, then releases cores.
// [RL13] Cache powered down in deep sleep when its control bit is set.
// [RL14] Software selects retained TCM amount in deep sleep, none to 384 kB.
// [RL15] NVM powered down in deep sleep when its control bit is set; code turns NVM off in every deep state, bit only acts in SPSC_ST_W_OSC.
module spsc_ctrl
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_cores_sleep,
  input wire logic i_cores_deep,
  input wire logic i_periph_idle,
  input wire logic i_wake,
  output logic o_core_run,
  output logic o_core_clk_en,
  output logic o_periph_clk_en,
  output logic o_cpu_pwr_on,
  output logic o_periph_pwr_on,
  output logic o_nvm_on,
  output logic o_nvm_standby,
  output logic o_cache_on,
  output logic o_cache_ret,
  output logic [6:0] o_tcm_bank_ret,
  output logic o_tcm_all_on,
  output logic o_high_freq_rc_osc_en,
  output logic o_low_freq_rc_osc_en,
  output logic o_crystal_osc_en,
  output logic o_timer_run,
  output logic o_cpu_state_ret
);
  import spsc_pkg::*;

  spsc_state_t st_r, st_nxt;
  spsc_req_t req_r, req_nxt;
  logic [31:0] retcfg_r, retcfg_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [6:0] bank_ret;
  logic wr_acc, rd_acc, hit;

  // Address decode used only by the slave error path
  function automatic logic addr_ok(input logic [11:0] a);
    addr_ok = (a == `SPSC_ADDR_CTRL) || (a == `SPSC_ADDR_RETCFG) || (a == `SPSC_ADDR_STATUS);
  endfunction

  function automatic logic is_deep(input spsc_state_t s);
    is_deep = (s == SPSC_ST_DS0) || (s == SPSC_ST_DS1) || (s == SPSC_ST_DS2)
      || (s == SPSC_ST_DS3);
  endfunction

  assign hit = addr_ok(i_paddr);
  assign wr_acc = i_psel && i_penable && i_pwrite;
  assign rd_acc = i_psel && i_penable && !i_pwrite;
  assign o_pready = 1'b1; // Zero wait states
  assign o_pslverr = i_psel && i_penable && !hit;
  assign o_prdata = rdata_r;

  // TCM bank retention decode
  spsc_tcm_ret spsc_tcm_ret_inst
  (
    .i_sel (retcfg_r[`SPSC_RET_TCM_LSB +: 3]), // [RL14]
    .o_bank_ret (bank_ret)
  );

  // Register file next values
  always_comb
  begin
    req_nxt = req_r;
    retcfg_nxt = retcfg_r;
    rdata_nxt = rdata_r;
    if (wr_acc && i_paddr == `SPSC_ADDR_CTRL)
    begin
      req_nxt = spsc_req_t'(i_pwdata[`SPSC_CTRL_REQ_LSB +: `SPSC_CTRL_REQ_W]);
    end
    if (wr_acc && i_paddr == `SPSC_ADDR_RETCFG)
    begin
      retcfg_nxt = {26'h0, i_pwdata[5:0]};
    end
    // Read data captured in the setup phase for this transfer's access phase
    if (i_psel && !i_penable && !i_pwrite)
    begin
      case (i_paddr)
        `SPSC_ADDR_CTRL: rdata_nxt = {29'h0, req_r};
        `SPSC_ADDR_RETCFG: rdata_nxt = retcfg_r;
        `SPSC_ADDR_STATUS: rdata_nxt = {27'h0, o_core_run, st_r};
        default: rdata_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      req_r <= SPSC_REQ_ACT; // Power return starts from defaults [RL11]
      retcfg_r <= `SPSC_RETCFG_RST;
      rdata_r <= 32'h0;
    end
    else
    begin
      req_r <= req_nxt;
      retcfg_r <= retcfg_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Power state sequencer
  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = (cnt_r != 4'h0) ? cnt_r - 4'h1 : 4'h0;
    case (st_r)
      SPSC_ST_ACT:
      begin
        if (i_cores_sleep && !i_wake)
        begin
          case (req_r)
            SPSC_REQ_S0: st_nxt = SPSC_ST_S0; // [RL2]
            SPSC_REQ_S1: st_nxt = i_periph_idle ? SPSC_ST_S1 : SPSC_ST_S0; // [RL4]
            SPSC_REQ_DS0: st_nxt = i_cores_deep ? SPSC_ST_DS0 : SPSC_ST_ACT;
            SPSC_REQ_DS1: st_nxt = i_cores_deep ? SPSC_ST_DS1 : SPSC_ST_ACT;
            SPSC_REQ_DS2: st_nxt = i_cores_deep ? SPSC_ST_DS2 : SPSC_ST_ACT; // [RL9]
            SPSC_REQ_DS3: st_nxt = i_cores_deep ? SPSC_ST_DS3 : SPSC_ST_ACT;
            default: st_nxt = SPSC_ST_ACT;
          endcase
        end
      end
      SPSC_ST_S0, SPSC_ST_S1, SPSC_ST_DS0, SPSC_ST_DS1, SPSC_ST_DS2, SPSC_ST_DS3:
      begin
        if (i_wake)
        begin
          st_nxt = SPSC_ST_W_OSC; // [RL12]
          cnt_nxt = 4'(`SPSC_WAKE_STEP_CYC);
        end
      end
      SPSC_ST_W_OSC:
      begin
        if (cnt_r == 4'h0)
        begin
          st_nxt = SPSC_ST_W_PWR; // [RL12]
          cnt_nxt = 4'(`SPSC_WAKE_STEP_CYC);
        end
      end
      SPSC_ST_W_PWR:
      begin
        if (cnt_r == 4'h0)
        begin
          st_nxt = SPSC_ST_W_CLK;
          cnt_nxt = 4'(`SPSC_WAKE_STEP_CYC);
        end
      end
      SPSC_ST_W_CLK:
      begin
        if (cnt_r == 4'h0)
        begin
          st_nxt = SPSC_ST_ACT;
        end
      end
      default: st_nxt = SPSC_ST_ACT;
    endcase
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      st_r <= SPSC_ST_ACT;
      cnt_r <= 4'h0;
    end
    else
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Per-state controls for oscillators, domains, clocks and memory
  always_comb
  begin
    o_core_run = (st_r == SPSC_ST_ACT); // [RL1]
    o_core_clk_en = (st_r == SPSC_ST_ACT) || (st_r == SPSC_ST_W_CLK); // [RL3]
    o_periph_clk_en = (st_r == SPSC_ST_ACT) || (st_r == SPSC_ST_S0)
      || (st_r == SPSC_ST_DS0) || (st_r == SPSC_ST_DS1)
      || (st_r == SPSC_ST_W_CLK); // [RL5]
    o_cpu_pwr_on = !is_deep(st_r) && (st_r != SPSC_ST_W_OSC); // [RL6]
    o_periph_pwr_on = !(st_r == SPSC_ST_DS2 || st_r == SPSC_ST_DS3
      || st_r == SPSC_ST_W_OSC); // [RL8]
    o_nvm_on = !is_deep(st_r)
      && !(st_r == SPSC_ST_W_OSC && retcfg_r[`SPSC_RET_NVM_BIT]); // [RL15]
    o_nvm_standby = (st_r == SPSC_ST_S0) || (st_r == SPSC_ST_S1); // [RL3]
    o_cache_on = !is_deep(st_r) || !retcfg_r[`SPSC_RET_CACHE_BIT]; // [RL13]
    o_cache_ret = is_deep(st_r) && o_cache_on;
    o_tcm_all_on = !is_deep(st_r); // [RL3]
    o_tcm_bank_ret = 7'h0;
    o_high_freq_rc_osc_en = !(st_r == SPSC_ST_DS2 || st_r == SPSC_ST_DS3);
    o_low_freq_rc_osc_en = (st_r == SPSC_ST_DS3); // [RL10]
    o_crystal_osc_en = (st_r != SPSC_ST_DS3);
    o_timer_run = 1'b1; // [RL10]
    o_cpu_state_ret = is_deep(st_r);
    case (st_r)
      SPSC_ST_DS0:
      begin
        o_nvm_on = 1'b0; // [RL6]
        o_tcm_bank_ret = bank_ret;
      end
      SPSC_ST_DS1:
      begin
        o_nvm_on = 1'b0;
        o_cache_on = 1'b0; // [RL7]
        o_cache_ret = 1'b0;
        o_tcm_bank_ret = bank_ret;
      end
      SPSC_ST_DS2:
      begin
        o_nvm_on = 1'b0;
        o_cache_on = 1'b0; // [RL8]
        o_cache_ret = 1'b0;
        o_tcm_bank_ret = bank_ret;
      end
      SPSC_ST_DS3:
      begin
        o_nvm_on = 1'b0;
        o_cache_on = 1'b0; // [RL10]
        o_cache_ret = 1'b0;
        o_tcm_bank_ret = 7'h0;
      end
      default:
      begin
        o_tcm_bank_ret = 7'h0;
      end
    endcase
  end

  // Entry conditions, per-state controls and wake order
  property p_sleep_needs_cores;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (st_r == SPSC_ST_S0 && $past(st_r) == SPSC_ST_ACT) |-> $past(i_cores_sleep);
  endproperty
  a_sleep_needs_cores: assert property (p_sleep_needs_cores) else $error("sleep0 without cores asleep"); // [RL2]

  property p_s1_needs_idle;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (st_r == SPSC_ST_S1 && $past(st_r) == SPSC_ST_ACT)
        |-> ($past(i_periph_idle) && $past(i_cores_sleep));
  endproperty
  a_s1_needs_idle: assert property (p_s1_needs_idle) else $error("sleep1 with busy periph"); // [RL4]

  property p_s1_clocks;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (st_r == SPSC_ST_S1) |-> (!o_core_clk_en && !o_periph_clk_en && o_high_freq_rc_osc_en);
  endproperty
  a_s1_clocks: assert property (p_s1_clocks) else $error("sleep1 clocks wrong"); // [RL5]

  property p_ds1_cache_off;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (st_r == SPSC_ST_DS1) |-> (!o_cache_on && !o_nvm_on && !o_cpu_pwr_on);
  endproperty
  a_ds1_cache_off: assert property (p_ds1_cache_off) else $error("deep1 cache or nvm on"); // [RL7]

  property p_ds3_osc;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (st_r == SPSC_ST_DS3) |-> (o_low_freq_rc_osc_en && !o_high_freq_rc_osc_en
        && !o_crystal_osc_en && o_tcm_bank_ret == 7'h0);
  endproperty
  a_ds3_osc: assert property (p_ds3_osc) else $error("deep3 oscillators wrong"); // [RL10]

  property p_ds2_osc;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (st_r == SPSC_ST_DS2) |-> (!o_high_freq_rc_osc_en && o_crystal_osc_en && !o_periph_pwr_on);
  endproperty
  a_ds2_osc: assert property (p_ds2_osc) else $error("deep2 controls wrong"); // [RL8]

  property p_wake_seq;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      ((st_r == SPSC_ST_S0 || st_r == SPSC_ST_S1 || is_deep(st_r)) && i_wake)
        |=> (st_r == SPSC_ST_W_OSC && o_high_freq_rc_osc_en && !o_core_run)
        ##9 (st_r == SPSC_ST_W_PWR && o_cpu_pwr_on && !o_core_clk_en)
        ##9 (st_r == SPSC_ST_W_CLK && o_core_clk_en && !o_core_run)
        ##9 o_core_run;
  endproperty
  a_wake_seq: assert property (p_wake_seq) else $error("wake sequence wrong"); // [RL12]

  property p_active_power;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      o_core_run |-> (o_cpu_pwr_on && o_nvm_on && o_tcm_all_on && o_core_clk_en);
  endproperty
  a_active_power: assert property (p_active_power) else $error("active not powered"); // [RL1]

  property p_nvm_ctrl;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (st_r == SPSC_ST_S0) |-> (o_nvm_standby && o_nvm_on && o_tcm_all_on);
  endproperty
  a_nvm_ctrl: assert property (p_nvm_ctrl) else $error("sleep0 memory wrong"); // [RL3]

  c_enter_s0: cover property (@(posedge i_core_clk) disable iff (!i_rst_n) st_r == SPSC_ST_S0);
  c_enter_ds2: cover property (@(posedge i_core_clk) disable iff (!i_rst_n) st_r == SPSC_ST_DS2);
  c_enter_ds3: cover property (@(posedge i_core_clk) disable iff (!i_rst_n) st_r == SPSC_ST_DS3);
  c_wake_done: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
    st_r == SPSC_ST_W_CLK ##1 st_r == SPSC_ST_ACT);
endmodule // spsc_ctrl

// File: hw/spsc_defines.svh
// Constants for the system power state controller
`ifndef SPSC_DEFINES_SVH
`define SPSC_DEFINES_SVH
`define SPSC_ADDR_CTRL 12'h000
`define SPSC_ADDR_RETCFG 12'h004
`define SPSC_ADDR_STATUS 12'h008
`define SPSC_CTRL_REQ_LSB 0
`define SPSC_CTRL_REQ_W 3
`define SPSC_RET_TCM_LSB 0
`define SPSC_RET_CACHE_BIT 4
`define SPSC_RET_NVM_BIT 5
`define SPSC_RETCFG_RST 32'h0000_0000
`define SPSC_WAKE_STEP_NS 64
`define SPSC_CLK_NS 8
`define SPSC_WAKE_STEP_CYC ((`SPSC_WAKE_STEP_NS + `SPSC_CLK_NS - 1) / `SPSC_CLK_NS)
`define SPSC_NUM_TCM_BANKS 7
`endif

// File: hw/spsc_pkg.sv
// Types for the system power state controller
package spsc_pkg;
  typedef enum logic [2:0] {
    SPSC_REQ_ACT, SPSC_REQ_S0, SPSC_REQ_S1, SPSC_REQ_DS0,
    SPSC_REQ_DS1, SPSC_REQ_DS2, SPSC_REQ_DS3, SPSC_REQ_RSV
  } spsc_req_t;
  typedef enum logic [3:0] {
    SPSC_ST_ACT, SPSC_ST_S0, SPSC_ST_S1, SPSC_ST_DS0, SPSC_ST_DS1,
    SPSC_ST_DS2, SPSC_ST_DS3, SPSC_ST_W_OSC, SPSC_ST_W_PWR, SPSC_ST_W_CLK
  } spsc_state_t;
endpackage

// File: hw/spsc_tcm_ret.sv
// TCM retention bank decoder for the system power state controller
`timescale 1ns/1ps
`include "spsc_defines.svh"
module spsc_tcm_ret
(
  input wire logic [2:0] i_sel,
  output logic [6:0] o_bank_ret
);
  // Banks of 32,64,32,128,96,32 kB; cumulative sizes 32,96,128,256,352,384
  logic [2:0] nbank;
  always_comb
  begin
    nbank = (i_sel > 3'h6) ? 3'h6 : i_sel;
  end
  // One retention enable per bank
  genvar g;
  generate
    for (g = 0; g < 6; g++)
    begin : g_bank
      assign o_bank_ret[g] = (nbank > 3'(g));
    end
  endgenerate
  assign o_bank_ret[6] = 1'b0;
endmodule // spsc_tcm_ret

// File: bench/spsc_ctrl_tb_top.sv
// Self-checking testbench for the system power state controller
`timescale 1ns/1ps
`include "spsc_defines.svh"
module spsc_ctrl_tb_top;
  import spsc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic sleep = 1'b0;
  logic deep = 1'b0;
  logic idle = 1'b0;
  logic wake = 1'b0;
  logic nvm_cut = 1'b0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err;
  logic core_run, core_clk, per_clk, cpu_pwr, per_pwr, nvm_on, nvm_sb;
  logic cache_on, cache_ret, tcm_all, hf, lf, xo, tmr, cpu_ret;
  logic [6:0] tcm;
  int checks = 0;
  int bad_count = 0;
  spsc_ctrl spsc_ctrl_inst (.i_core_clk(clk), .i_rst_n(rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_cores_sleep(sleep),
    .i_cores_deep(deep), .i_periph_idle(idle), .i_wake(wake), .o_core_run(core_run),
    .o_core_clk_en(core_clk), .o_periph_clk_en(per_clk), .o_cpu_pwr_on(cpu_pwr),
    .o_periph_pwr_on(per_pwr), .o_nvm_on(nvm_on), .o_nvm_standby(nvm_sb),
    .o_cache_on(cache_on), .o_cache_ret(cache_ret), .o_tcm_bank_ret(tcm),
    .o_tcm_all_on(tcm_all), .o_high_freq_rc_osc_en(hf), .o_low_freq_rc_osc_en(lf),
    .o_crystal_osc_en(xo), .o_timer_run(tmr), .o_cpu_state_ret(cpu_ret));
  // Clock at 125 MHz
  initial
  begin
    forever #4 clk = ~clk;
  end
  // Verdict and end of run
  task finish_test();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Compare seen against expected
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One APB transfer, waits for pready
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (wr && a == `SPSC_ADDR_RETCFG)
      nvm_cut = d[`SPSC_RET_NVM_BIT];
    if (n == 20)
    begin
      bad_count++;
      finish_test();
    end
  endtask
  // Program request and core status, let state settle
  task enter(input spsc_req_t r, input logic s, input logic d, input logic i);
    apb(1'b1, `SPSC_ADDR_CTRL, {29'h0, r});
    @(posedge clk);
    sleep <= s;
    deep <= d;
    idle <= i;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // Wake and time the restart sequence
  task do_wake();
    int n;
    @(posedge clk);
    wake <= 1'b1;
    sleep <= 1'b0;
    deep <= 1'b0;
    for (n = 1; n < 40; n++)
    begin
      @(posedge clk);
      wake <= 1'b0;
      #1;
      if (n == 1)
      begin
        chk({hf, core_run}, 2'b10);
        chk(nvm_on, !nvm_cut);
      end
      if (core_run === 1'b1)
        break;
    end
    chk(n, 28);
    chk({core_clk, per_clk, cpu_pwr}, 3'b111);
    if (n == 40)
      finish_test();
  endtask
  // Reset values, register access, unmapped address
  task t_regs();
    chk({core_run, cpu_pwr, nvm_on, tcm_all, pready, lf}, 6'b111110);
    apb(1'b0, `SPSC_ADDR_STATUS, 32'h0);
    chk(rd, 32'h10);
    apb(1'b0, `SPSC_ADDR_RETCFG, 32'h0);
    chk(rd, `SPSC_RETCFG_RST);
    apb(1'b1, `SPSC_ADDR_RETCFG, 32'h25);
    apb(1'b0, `SPSC_ADDR_RETCFG, 32'h0);
    chk(rd, 32'h25);
    apb(1'b0, 12'h00c, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
  endtask
  // Sleep levels zero and one with their entry conditions
  task t_sleep();
    enter(SPSC_REQ_S0, 1'b0, 1'b0, 1'b1);
    chk(core_run, 1'b1);
    enter(SPSC_REQ_RSV, 1'b1, 1'b1, 1'b1);
    chk(core_run, 1'b1);
    enter(SPSC_REQ_S0, 1'b1, 1'b0, 1'b0);
    chk({core_run, core_clk, per_clk, hf, nvm_sb, cpu_pwr}, 6'b001111);
    do_wake();
    enter(SPSC_REQ_S1, 1'b1, 1'b0, 1'b0);
    chk({core_clk, per_clk}, 2'b01);
    do_wake();
    enter(SPSC_REQ_S1, 1'b1, 1'b0, 1'b1);
    chk({core_run, core_clk, per_clk, hf, nvm_sb, cpu_pwr}, 6'b000111);
    do_wake();
  endtask
  // Deep sleep zero with every retention size, then deep sleep one
  task t_deep();
    int s;
    enter(SPSC_REQ_DS0, 1'b1, 1'b0, 1'b1);
    chk(core_run, 1'b1);
    for (s = 0; s < 7; s++)
    begin
      apb(1'b1, `SPSC_ADDR_RETCFG, s);
      enter(SPSC_REQ_DS0, 1'b1, 1'b1, 1'b1);
      chk(tcm, (7'h1 << s) - 7'h1);
      chk({cache_ret, nvm_on, cpu_pwr, hf, core_run, tcm_all}, 6'b100100);
      do_wake();
    end
    apb(1'b1, `SPSC_ADDR_RETCFG, 32'h13);
    enter(SPSC_REQ_DS0, 1'b1, 1'b1, 1'b1);
    chk({cache_on, cache_ret, tcm}, 9'h007);
    do_wake();
    apb(1'b1, `SPSC_ADDR_RETCFG, 32'h03);
    enter(SPSC_REQ_DS1, 1'b1, 1'b1, 1'b1);
    chk({cache_on, cache_ret, nvm_on, cpu_pwr, hf, tcm}, 12'h087);
    do_wake();
  endtask
  // Deep sleep two and three
  task t_deepest();
    apb(1'b1, `SPSC_ADDR_RETCFG, 32'h22);
    enter(SPSC_REQ_DS2, 1'b1, 1'b1, 1'b1);
    chk({hf, xo, cpu_ret, per_pwr, cache_on, nvm_on, cpu_pwr}, 7'b0110000);
    chk(tcm, 7'h03);
    do_wake();
    enter(SPSC_REQ_DS3, 1'b1, 1'b1, 1'b1);
    chk({lf, hf, xo, tmr, cpu_ret, per_pwr, nvm_on, cache_on, tcm}, 15'h4c00);
    do_wake();
  endtask
  // Supply loss in deep sleep and return to defaults
  task t_off();
    apb(1'b1, `SPSC_ADDR_RETCFG, 32'h15);
    enter(SPSC_REQ_DS3, 1'b1, 1'b1, 1'b1);
    chk(lf, 1'b1);
    @(posedge clk);
    rst_n <= 1'b0;
    sleep <= 1'b0;
    deep <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk({core_run, cpu_pwr, lf, cpu_ret}, 4'b1100);
    apb(1'b0, `SPSC_ADDR_RETCFG, 32'h0);
    chk(rd, `SPSC_RETCFG_RST);
  endtask
  // Main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    t_regs();
    t_sleep();
    t_deep();
    t_deepest();
    t_off();
    finish_test();
  end
endmodule // spsc_ctrl_tb_top
